// *** logic/omic_cbal.sv ***
// counterbalance channel: limit cut-off of the power relays, brake valve gating, direction
`timescale 1ns/1ps
module omic_cbal
   import omic_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cmd_dir,
   input wire logic cmd_fwd,
   input wire logic cmd_rev,
   input wire logic cmd_brake,
   input wire logic lim_fwd_open,
   input wire logic lim_rev_open,
   output logic dir,
   output logic pwr_fwd,
   output logic pwr_rev,
   output logic brake_air,
   output logic limit_hit
);

   logic next_fwd;
   logic next_rev;

   // a relay only feeds power while its end limit is still closed
   always_comb begin
      next_fwd = cmd_fwd & ~lim_fwd_open;
      next_rev = cmd_rev & ~lim_rev_open;
   end

   // ****************************************
   // drive outputs
   // ****************************************
   // direction comes from the direction bit only, relays never steer it
   always_ff @(posedge clk) begin
      if (reset) begin
         dir <= 1'b0;
         pwr_fwd <= 1'b0;
         pwr_rev <= 1'b0;
         brake_air <= 1'b0;
         limit_hit <= 1'b0;
      end else begin
         dir <= cmd_dir;
         pwr_fwd <= next_fwd;
         pwr_rev <= next_rev;
         // brake air only while power flows, so a cut power path re-clamps
         brake_air <= cmd_brake & (next_fwd | next_rev);
         limit_hit <= (cmd_fwd & lim_fwd_open) | (cmd_rev & lim_rev_open);
      end
   end

endmodule : omic_cbal

// *** logic/omic_ctrl.sv ***
// top: interlock and drive logic for the optics support mechanisms, with Avalon-MM register slave
//
// Contract
// - rotator speed and direction reach the drive only while both covers are retracted
// - rotator drive offers high and low speed, forward and reverse
// - four normally-closed position switches; an open switch means position reached
// - the index switch opens at each of the three ports
// - each port switch opens only at its own port; index plus one
// - two counterbalance channels, identical and independent, each with direction, relays, brake
// - counterbalance direction follows the direction bit alone, not the relays
// - each counterbalance power path is cut by its end limit switch
// - brake holds when power is off; released only while its valve output is set
// - two lamp supplies each enabled by its own output; intensity from analog channels
// - each vacuum or air valve switched by its own relay from a host output
// - each cover half has a motor power enable and a direction output
// - each cover half reports a fully-open and a fully-closed switch
// - fold motor supply is inhibited while the covers are in place
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module omic_ctrl
   import omic_pkg::*;
#(
   parameter int NUM_VALVES = 4
)
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic SW_INDEX_OPEN,
   input wire logic [2:0] SW_PORT_OPEN,
   input wire logic PIN_ENGAGED,
   input wire logic COV_L_OPENED,
   input wire logic COV_L_CLOSED,
   input wire logic COV_R_OPENED,
   input wire logic COV_R_CLOSED,
   input wire logic CB0_LIM_FWD_OPEN,
   input wire logic CB0_LIM_REV_OPEN,
   input wire logic CB1_LIM_FWD_OPEN,
   input wire logic CB1_LIM_REV_OPEN,
   output logic ROT_RUN,
   output logic ROT_REV,
   output logic ROT_HIGH,
   output logic PIN_RETRACT,
   output logic CB0_DIR,
   output logic CB0_PWR_FWD,
   output logic CB0_PWR_REV,
   output logic CB0_BRAKE_AIR,
   output logic CB1_DIR,
   output logic CB1_PWR_FWD,
   output logic CB1_PWR_REV,
   output logic CB1_BRAKE_AIR,
   output logic LAMP0_EN,
   output logic LAMP1_EN,
   output logic [NUM_VALVES-1:0] VALVE_EN,
   output logic COV_L_PWR,
   output logic COV_L_DIR,
   output logic COV_R_PWR,
   output logic COV_R_DIR,
   output logic FOLD_PWR,
   output logic FOLD_DIR
);

   // ****************************************
   // declarations
   // ****************************************
   localparam logic [31:0] VALVE_MASK = 32'((64'h1 << NUM_VALVES) - 64'h1) << AUX_VALVE_LSB;
   localparam logic [31:0] AUX_MASK = AUX_FIXED_MASK | VALVE_MASK;

   omic_bus_e bus_state;
   logic [31:0] rot_ctrl;
   logic [31:0] cb_ctrl;
   logic [31:0] aux_ctrl;
   logic [EVT_W-1:0] evt;
   logic [EVT_W-1:0] next_evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [31:0] stat;
   logic [31:0] next_rdata;
   logic [31:0] be_mask;
   logic wr_commit;
   logic in_index;
   logic [2:0] in_port;
   logic in_pin;
   logic [3:0] in_cov;
   logic [3:0] in_lim;
   logic retracted;
   logic port_valid;
   logic [1:0] port_code;
   logic pos_fault;
   logic cb0_hit;
   logic cb1_hit;

   // ****************************************
   // input sampling
   // ****************************************
   // one register stage so status and gating see a single coherent snapshot
   always_ff @(posedge CLK) begin
      if (RESET) begin
         in_index <= 1'b0;
         in_port <= 3'h0;
         in_pin <= 1'b0;
         in_cov <= 4'h0;
         in_lim <= 4'h0;
      end else begin
         in_index <= SW_INDEX_OPEN;
         in_port <= SW_PORT_OPEN;
         in_pin <= PIN_ENGAGED;
         in_cov <= {COV_R_CLOSED, COV_R_OPENED, COV_L_CLOSED, COV_L_OPENED};
         in_lim <= {CB1_LIM_REV_OPEN, CB1_LIM_FWD_OPEN, CB0_LIM_REV_OPEN, CB0_LIM_FWD_OPEN};
      end
   end

   // ****************************************
   // position decode and cover state
   // ****************************************
   // valid only with index open and exactly one port switch open
   always_comb begin
      retracted = in_cov[0] & in_cov[2];
      port_valid = in_index & ((in_port == 3'h1) | (in_port == 3'h2) | (in_port == 3'h4));
      case (in_port)
         3'h1: port_code = 2'h1;
         3'h2: port_code = 2'h2;
         3'h4: port_code = 2'h3;
         default: port_code = 2'h0;
      endcase
      // a stopped rotator with some switch open but no valid pattern is worth flagging
      pos_fault = ~ROT_RUN & ~port_valid & (in_index | (in_port != 3'h0));
   end

   // ****************************************
   // rotator and latch pin drive
   // ****************************************
   // covers closed would be struck by the rotator, so run, reverse and speed drop; pin is not gated
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ROT_RUN <= 1'b0;
         ROT_REV <= 1'b0;
         ROT_HIGH <= 1'b0;
         PIN_RETRACT <= 1'b0;
      end else begin
         ROT_RUN <= rot_ctrl[ROT_RUN_BIT] & retracted;
         ROT_REV <= rot_ctrl[ROT_REV_BIT] & retracted;
         ROT_HIGH <= rot_ctrl[ROT_HIGH_BIT] & retracted;
         // no pin-versus-motion lock here: host software owns that interlock
         PIN_RETRACT <= rot_ctrl[ROT_PIN_BIT];
      end
   end

   // ****************************************
   // fold, covers, lamps and valves
   // ****************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         FOLD_PWR <= 1'b0;
         FOLD_DIR <= 1'b0;
         COV_L_PWR <= 1'b0;
         COV_L_DIR <= 1'b0;
         COV_R_PWR <= 1'b0;
         COV_R_DIR <= 1'b0;
         LAMP0_EN <= 1'b0;
         LAMP1_EN <= 1'b0;
         VALVE_EN <= '0;
      end else begin
         FOLD_PWR <= aux_ctrl[AUX_FOLD_RUN_BIT] & retracted;
         FOLD_DIR <= aux_ctrl[AUX_FOLD_DIR_BIT];
         COV_L_PWR <= aux_ctrl[AUX_COVL_PWR_BIT];
         COV_L_DIR <= aux_ctrl[AUX_COVL_DIR_BIT];
         COV_R_PWR <= aux_ctrl[AUX_COVR_PWR_BIT];
         COV_R_DIR <= aux_ctrl[AUX_COVR_DIR_BIT];
         LAMP0_EN <= aux_ctrl[AUX_LAMP0_BIT];
         LAMP1_EN <= aux_ctrl[AUX_LAMP1_BIT];
         VALVE_EN <= aux_ctrl[AUX_VALVE_LSB +: NUM_VALVES];
      end
   end

   // ****************************************
   // counterbalance channels
   // ****************************************
   // same logic twice, no shared state between the two
   omic_cbal u_cbal0 (
      .clk(CLK),
      .reset(RESET),
      .cmd_dir(cb_ctrl[CB_DIR_BIT]),
      .cmd_fwd(cb_ctrl[CB_FWD_BIT]),
      .cmd_rev(cb_ctrl[CB_REV_BIT]),
      .cmd_brake(cb_ctrl[CB_BRK_BIT]),
      .lim_fwd_open(in_lim[0]),
      .lim_rev_open(in_lim[1]),
      .dir(CB0_DIR),
      .pwr_fwd(CB0_PWR_FWD),
      .pwr_rev(CB0_PWR_REV),
      .brake_air(CB0_BRAKE_AIR),
      .limit_hit(cb0_hit)
   );

   omic_cbal u_cbal1 (
      .clk(CLK),
      .reset(RESET),
      .cmd_dir(cb_ctrl[CB_STRIDE + CB_DIR_BIT]),
      .cmd_fwd(cb_ctrl[CB_STRIDE + CB_FWD_BIT]),
      .cmd_rev(cb_ctrl[CB_STRIDE + CB_REV_BIT]),
      .cmd_brake(cb_ctrl[CB_STRIDE + CB_BRK_BIT]),
      .lim_fwd_open(in_lim[2]),
      .lim_rev_open(in_lim[3]),
      .dir(CB1_DIR),
      .pwr_fwd(CB1_PWR_FWD),
      .pwr_rev(CB1_PWR_REV),
      .brake_air(CB1_BRAKE_AIR),
      .limit_hit(cb1_hit)
   );

   // ****************************************
   // bus handshake
   // ****************************************
   // fixed one wait cycle: waitrequest drops in the cycle after the request
   always_ff @(posedge CLK) begin
      if (RESET) begin
         bus_state <= BUS_IDLE;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (AVS_READ | AVS_WRITE) begin
                  bus_state <= BUS_ACK;
                  AVS_WAITREQUEST <= 1'b0;
               end
            end
            BUS_ACK: begin
               bus_state <= BUS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
            default: begin
               bus_state <= BUS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   // write lands on the edge where waitrequest is seen low
   always_comb begin
      wr_commit = (bus_state == BUS_ACK) & AVS_WRITE;
      be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                 {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rot_ctrl <= RST_CTRL;
         cb_ctrl <= RST_CTRL;
         aux_ctrl <= RST_CTRL;
      end else if (wr_commit) begin
         case ({AVS_ADDRESS[4:2], 2'b00})
            OFS_ROT: rot_ctrl <= ((rot_ctrl & ~be_mask) | (AVS_WRITEDATA & be_mask)) & ROT_MASK;
            OFS_CB: cb_ctrl <= ((cb_ctrl & ~be_mask) | (AVS_WRITEDATA & be_mask)) & CB_MASK;
            OFS_AUX: aux_ctrl <= ((aux_ctrl & ~be_mask) | (AVS_WRITEDATA & be_mask)) & AUX_MASK;
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // sticky events
   // ****************************************
   // a set in the same cycle as its clear survives the clear
   always_comb begin
      next_evt_set = '0;
      next_evt_set[EVT_ROT_BLOCK] = rot_ctrl[ROT_RUN_BIT] & ~retracted;
      next_evt_set[EVT_FOLD_BLOCK] = aux_ctrl[AUX_FOLD_RUN_BIT] & ~retracted;
      next_evt_set[EVT_LIMIT0] = cb0_hit;
      next_evt_set[EVT_LIMIT1] = cb1_hit;
      next_evt_set[EVT_POS_FAULT] = pos_fault;
      evt_clr = '0;
      if (wr_commit && ({AVS_ADDRESS[4:2], 2'b00} == OFS_EVT) && AVS_BYTEENABLE[0]) begin
         evt_clr = AVS_WRITEDATA[EVT_W-1:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         evt <= '0;
      end else begin
         evt <= (evt & ~evt_clr) | next_evt_set;
      end
   end

   // ****************************************
   // status word and read mux
   // ****************************************
   always_comb begin
      stat = 32'h00000000;
      stat[STAT_PORT_LSB +: 2] = port_valid ? port_code : 2'h0;
      stat[STAT_PORT_VALID] = port_valid;
      stat[STAT_POS_FAULT] = pos_fault;
      stat[STAT_COV_RETRACT] = retracted;
      stat[STAT_PIN_ENGAGED] = in_pin;
      stat[STAT_ROT_MOVING] = ROT_RUN;
      stat[STAT_FOLD_INHIBIT] = ~retracted;
      stat[STAT_SW_LSB +: 4] = {in_port, in_index};
      stat[STAT_COV_SW_LSB +: 4] = in_cov;
      stat[STAT_LIM_LSB +: 4] = in_lim;
      case ({AVS_ADDRESS[4:2], 2'b00})
         OFS_ROT: next_rdata = rot_ctrl;
         OFS_CB: next_rdata = cb_ctrl;
         OFS_AUX: next_rdata = aux_ctrl;
         OFS_STAT: next_rdata = stat;
         OFS_EVT: next_rdata = {{(32-EVT_W){1'b0}}, evt};
         OFS_ID: next_rdata = ID_VALUE;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // read data latched as waitrequest drops, held until the next read
   always_ff @(posedge CLK) begin
      if (RESET) begin
         AVS_READDATA <= 32'h00000000;
      end else if ((bus_state == BUS_IDLE) && AVS_READ) begin
         AVS_READDATA <= next_rdata;
      end
   end

endmodule : omic_ctrl

// *** logic/omic_pkg.sv ***
// package: register map, field positions and reset values of the optics mechanism interlock block
package omic_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [4:0] OFS_ROT = 5'h00;
   localparam logic [4:0] OFS_CB = 5'h04;
   localparam logic [4:0] OFS_AUX = 5'h08;
   localparam logic [4:0] OFS_STAT = 5'h0C;
   localparam logic [4:0] OFS_EVT = 5'h10;
   localparam logic [4:0] OFS_ID = 5'h14;

   // ****************************************
   // rotator control fields
   // ****************************************
   localparam int ROT_RUN_BIT = 0;
   localparam int ROT_REV_BIT = 1;
   localparam int ROT_HIGH_BIT = 2;
   localparam int ROT_PIN_BIT = 3;
   localparam logic [31:0] ROT_MASK = 32'h0000000F;

   // ****************************************
   // counterbalance fields, one nibble per channel
   // ****************************************
   localparam int CB_DIR_BIT = 0;
   localparam int CB_FWD_BIT = 1;
   localparam int CB_REV_BIT = 2;
   localparam int CB_BRK_BIT = 3;
   localparam int CB_STRIDE = 4;
   localparam logic [31:0] CB_MASK = 32'h000000FF;

   // ****************************************
   // auxiliary control fields
   // ****************************************
   localparam int AUX_LAMP0_BIT = 0;
   localparam int AUX_LAMP1_BIT = 1;
   localparam int AUX_VALVE_LSB = 8;
   localparam int AUX_COVL_PWR_BIT = 16;
   localparam int AUX_COVL_DIR_BIT = 17;
   localparam int AUX_COVR_PWR_BIT = 18;
   localparam int AUX_COVR_DIR_BIT = 19;
   localparam int AUX_FOLD_RUN_BIT = 20;
   localparam int AUX_FOLD_DIR_BIT = 21;
   localparam logic [31:0] AUX_FIXED_MASK = 32'h003F0003;

   // ****************************************
   // status fields
   // ****************************************
   localparam int STAT_PORT_LSB = 0;
   localparam int STAT_PORT_VALID = 2;
   localparam int STAT_POS_FAULT = 3;
   localparam int STAT_COV_RETRACT = 4;
   localparam int STAT_PIN_ENGAGED = 5;
   localparam int STAT_ROT_MOVING = 6;
   localparam int STAT_FOLD_INHIBIT = 7;
   localparam int STAT_SW_LSB = 8;
   localparam int STAT_COV_SW_LSB = 12;
   localparam int STAT_LIM_LSB = 16;

   // ****************************************
   // sticky event bits, write one to clear
   // ****************************************
   localparam int EVT_ROT_BLOCK = 0;
   localparam int EVT_FOLD_BLOCK = 1;
   localparam int EVT_LIMIT0 = 2;
   localparam int EVT_LIMIT1 = 3;
   localparam int EVT_POS_FAULT = 4;
   localparam int EVT_W = 5;

   // ****************************************
   // reset values and identity
   // ****************************************
   localparam logic [31:0] RST_CTRL = 32'h00000000;
   localparam logic [31:0] ID_VALUE = 32'h0A5C0001; // arbitrary value

   typedef enum {BUS_IDLE, BUS_ACK} omic_bus_e;

endpackage : omic_pkg

// *** testbench/omic_ctrl_assertions.sv ***
// checker: interlock and handshake properties at the ports of the top module
`timescale 1ns/1ps
module omic_ctrl_assertions (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   input wire logic COV_L_OPENED,
   input wire logic COV_R_OPENED,
   input wire logic CB0_LIM_FWD_OPEN,
   input wire logic CB0_LIM_REV_OPEN,
   input wire logic CB1_LIM_FWD_OPEN,
   input wire logic CB1_LIM_REV_OPEN,
   input wire logic ROT_RUN,
   input wire logic ROT_REV,
   input wire logic ROT_HIGH,
   input wire logic CB0_PWR_FWD,
   input wire logic CB0_PWR_REV,
   input wire logic CB0_BRAKE_AIR,
   input wire logic CB1_PWR_FWD,
   input wire logic CB1_PWR_REV,
   input wire logic CB1_BRAKE_AIR,
   input wire logic FOLD_PWR
);
   default clocking dc @(posedge CLK); endclocking
   default disable iff (RESET);

   // ********
   // drive gating; inputs are sampled one edge, outputs follow on the next
   // ********
   sequence s_rot_stopped;
      !ROT_RUN && !ROT_REV && !ROT_HIGH;
   endsequence
   a_rot_cov_gate: assert property (!(COV_L_OPENED && COV_R_OPENED) |-> ##2 s_rot_stopped)
      else $error("rotator drive not blocked by covers");
   a_fold_cov_gate: assert property (FOLD_PWR |-> $past(COV_L_OPENED, 2) && $past(COV_R_OPENED, 2))
      else $error("fold power without retracted covers");
   a_cb0_fwd_cut: assert property (CB0_LIM_FWD_OPEN |-> ##2 !CB0_PWR_FWD)
      else $error("ch0 forward relay not cut");
   a_cb0_rev_cut: assert property (CB0_LIM_REV_OPEN |-> ##2 !CB0_PWR_REV)
      else $error("ch0 reverse relay not cut");
   a_cb1_fwd_cut: assert property (CB1_LIM_FWD_OPEN |-> ##2 !CB1_PWR_FWD)
      else $error("ch1 forward relay not cut");
   a_cb1_rev_cut: assert property (CB1_LIM_REV_OPEN |-> ##2 !CB1_PWR_REV)
      else $error("ch1 reverse relay not cut");
   // brake air only with power on, so the brake holds whenever power is off
   a_cb0_brake_hold: assert property (CB0_BRAKE_AIR |-> CB0_PWR_FWD || CB0_PWR_REV)
      else $error("ch0 brake freed without power");
   a_cb1_brake_hold: assert property (CB1_BRAKE_AIR |-> CB1_PWR_FWD || CB1_PWR_REV)
      else $error("ch1 brake freed without power");

   // ********
   // register bus: exactly one wait cycle, then ready for one cycle
   // ********
   sequence s_one_wait;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_one_wait)
      else $error("bus answer not after one wait cycle");
   a_bus_idle_wait: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest dropped without request");
endmodule : omic_ctrl_assertions

bind omic_ctrl omic_ctrl_assertions omic_ctrl_assertions_i (.CLK(CLK), .RESET(RESET), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .COV_L_OPENED(COV_L_OPENED),
   .COV_R_OPENED(COV_R_OPENED), .CB0_LIM_FWD_OPEN(CB0_LIM_FWD_OPEN), .CB0_LIM_REV_OPEN(CB0_LIM_REV_OPEN),
   .CB1_LIM_FWD_OPEN(CB1_LIM_FWD_OPEN), .CB1_LIM_REV_OPEN(CB1_LIM_REV_OPEN), .ROT_RUN(ROT_RUN),
   .ROT_REV(ROT_REV), .ROT_HIGH(ROT_HIGH), .CB0_PWR_FWD(CB0_PWR_FWD), .CB0_PWR_REV(CB0_PWR_REV),
   .CB0_BRAKE_AIR(CB0_BRAKE_AIR), .CB1_PWR_FWD(CB1_PWR_FWD), .CB1_PWR_REV(CB1_PWR_REV),
   .CB1_BRAKE_AIR(CB1_BRAKE_AIR), .FOLD_PWR(FOLD_PWR));

// *** testbench/omic_ctrl_bench.sv ***
// bench: register, rotator, position, counterbalance and auxiliary tests of the interlock block
`timescale 1ns/1ps
module omic_ctrl_bench
   import omic_pkg::*;
;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [4:0] adr = 5'h00;
   logic rd_s = 1'h0;
   logic wr_s = 1'h0;
   logic [31:0] wdat = 32'h0;
   wire [31:0] rdat;
   wire wait_s;
   logic [1:0] port_at = 2'h0;
   logic idx_only = 1'h0;
   logic [1:0] cov_l = 2'h1;
   logic [1:0] cov_r = 2'h1;
   logic [3:0] cb_end = 4'h0;
   logic pin_eng = 1'h1;
   wire idx_open;
   wire [2:0] port_open;
   wire [3:0] cov_sw;
   wire [3:0] lim;
   wire [3:0] rot_o;
   wire [7:0] cb_o;
   wire [11:0] aux_o;
   logic [31:0] d;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;

   // 125 MHz
   always #4 clk = ~clk;

   omic_mech omic_mech_i (.port_at(port_at), .idx_only(idx_only), .cov_l(cov_l), .cov_r(cov_r),
      .cb_end(cb_end), .idx_open(idx_open), .port_open(port_open), .cov_sw(cov_sw), .lim_open(lim));
   omic_ctrl #(.NUM_VALVES(4)) omic_ctrl_i (.CLK(clk), .RESET(reset), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
      .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wait_s), .SW_INDEX_OPEN(idx_open), .SW_PORT_OPEN(port_open), .PIN_ENGAGED(pin_eng),
      .COV_L_OPENED(cov_sw[0]), .COV_L_CLOSED(cov_sw[1]), .COV_R_OPENED(cov_sw[2]), .COV_R_CLOSED(cov_sw[3]),
      .CB0_LIM_FWD_OPEN(lim[0]), .CB0_LIM_REV_OPEN(lim[1]), .CB1_LIM_FWD_OPEN(lim[2]),
      .CB1_LIM_REV_OPEN(lim[3]), .ROT_RUN(rot_o[0]), .ROT_REV(rot_o[1]), .ROT_HIGH(rot_o[2]),
      .PIN_RETRACT(rot_o[3]), .CB0_DIR(cb_o[0]), .CB0_PWR_FWD(cb_o[1]), .CB0_PWR_REV(cb_o[2]),
      .CB0_BRAKE_AIR(cb_o[3]), .CB1_DIR(cb_o[4]), .CB1_PWR_FWD(cb_o[5]), .CB1_PWR_REV(cb_o[6]),
      .CB1_BRAKE_AIR(cb_o[7]), .LAMP0_EN(aux_o[0]), .LAMP1_EN(aux_o[1]), .VALVE_EN(aux_o[5:2]),
      .COV_L_PWR(aux_o[6]), .COV_L_DIR(aux_o[7]), .COV_R_PWR(aux_o[8]), .COV_R_DIR(aux_o[9]),
      .FOLD_PWR(aux_o[10]), .FOLD_DIR(aux_o[11]));

   // ********
   // tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   // request held until the edge that sees waitrequest low; one idle edge after it
   // no wait limit of its own: only the hang guard ends a stuck access
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v, output logic [31:0] r);
      adr <= a;
      wdat <= v;
      rd_s <= !w;
      wr_s <= w;
      do begin
         @(posedge clk);
      end while (wait_s !== 1'h0);
      r = rdat;
      rd_s <= 1'h0;
      wr_s <= 1'h0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(1'h1, a, v, x);
   endtask : wr

   task automatic rd(input logic [4:0] a);
      bus(1'h0, a, 32'h0, d);
   endtask : rd

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask : done

   task results;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   // hang guard; the run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end

   // ********
   // test sequence
   // ********
   initial begin
      wt(16);
      reset <= 1'h0;
      wt(2);
      // identity, reset values, read-only and unmapped places
      wr(OFS_ID, 32'h0);
      wr(5'h18, 32'hFFFFFFFF);
      rd(OFS_ID);
      chk(d, ID_VALUE, "id");
      rd(5'h18);
      chk(d, 32'h0, "unmapped");
      for (int i = 0; i < 3; i++) begin
         rd(5'(4 * i));
         chk(d, RST_CTRL, "ctrl reset");
      end
      rd(OFS_STAT);
      chk(d & 32'hFF, 32'h30, "idle status");
      done("registers");
      // pin out first, then every speed and direction; run bit drops between moves
      wr(OFS_ROT, 32'h8);
      pin_eng <= 1'h0;
      for (int k = 8; k < 16; k++) begin
         wr(OFS_ROT, 32'(k));
         wt(1);
         chk(32'(rot_o), 32'(k), "rot select");
      end
      cov_l <= 2'h0;
      wt(3);
      chk(32'(rot_o), 32'h8, "rot blocked");
      rd(OFS_EVT);
      chk(d, 32'h1, "block event");
      cov_l <= 2'h1;
      wt(3);
      chk(32'(rot_o), 32'hF, "rot resumed");
      wr(OFS_ROT, 32'h8);
      wr(OFS_EVT, 32'h1F);
      rd(OFS_EVT);
      chk(d, 32'h0, "event clear");
      wr(OFS_ROT, 32'h0);
      pin_eng <= 1'h1;
      done("rotator");
      // each port gives index plus its own switch; index alone is a fault
      for (int p = 1; p < 4; p++) begin
         port_at <= 2'(p);
         wt(3);
         rd(OFS_STAT);
         chk(d & 32'hF0F, 32'((((1 << p) | 1) << 8) | 4 | p), "port");
      end
      idx_only <= 1'h1;
      wt(3);
      rd(OFS_STAT);
      chk(d & 32'hF0F, 32'h108, "fault");
      rd(OFS_EVT);
      chk(d, 32'h10, "fault event");
      idx_only <= 1'h0;
      wt(3);
      wr(OFS_EVT, 32'h1F);
      done("position");
      // both travel senses on each channel, stopped in between; the stop ahead opens
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CB, i ? 32'hBC : 32'hCB);
         wt(1);
         chk(32'(cb_o), i ? 32'hBC : 32'hCB, "cb run");
         cb_end <= i ? 4'h6 : 4'h9;
         wt(3);
         chk(32'(cb_o), i ? 32'h10 : 32'h01, "cb limit");
         rd(OFS_EVT);
         chk(d, 32'hC, "cb events");
         rd(OFS_STAT);
         chk(d >> 16, i ? 32'h6 : 32'h9, "cb switches");
         wr(OFS_CB, 32'h0);
         cb_end <= 4'h0;
         wr(OFS_EVT, 32'h1F);
      end
      done("counterbalance");
      // lamps, valves, cover halves and fold, both polarities of each bit
      port_at <= 2'h1;
      for (int i = 0; i < 2; i++) begin
         wr(OFS_AUX, i ? 32'h002A0A02 : 32'h00150501);
         wt(1);
         chk(32'(aux_o), i ? 32'hAAA : 32'h555, "aux");
      end
      wr(OFS_AUX, 32'h00150501);
      cov_l <= 2'h2;
      wt(3);
      chk(32'(aux_o), 32'h155, "fold blocked");
      rd(OFS_STAT);
      chk(d & 32'hF0F0, 32'h60A0, "cover status");
      rd(OFS_EVT);
      chk(d, 32'h2, "fold event");
      done("auxiliary");
      results();
   end
endmodule : omic_ctrl_bench

// *** testbench/omic_mech.sv ***
// far-side model: rotator, cover and counterbalance switches seen by the block
`timescale 1ns/1ps
module omic_mech (
   input wire logic [1:0] port_at,
   input wire logic idx_only,
   input wire logic [1:0] cov_l,
   input wire logic [1:0] cov_r,
   input wire logic [3:0] cb_end,
   output logic idx_open,
   output logic [2:0] port_open,
   output logic [3:0] cov_sw,
   output logic [3:0] lim_open
);
   // normally-closed switches open only at their spot; port_at 0 is between ports
   assign idx_open = port_at != 2'h0;
   // idx_only mimics a stuck port switch, so a faulty pattern can be shown
   assign port_open = idx_only ? 3'h0 : {port_at == 2'h3, port_at == 2'h2, port_at == 2'h1};
   // covers: 1 fully open, 2 fully closed, 0 travelling
   assign cov_sw = {cov_r == 2'h2, cov_r == 2'h1, cov_l == 2'h2, cov_l == 2'h1};
   // an end stop opens its limit switch whatever the relays do
   assign lim_open = cb_end;
endmodule : omic_mech
